// ---- rtl/ipt_pkg.sv ----
// package: constants and carrier types of the interrupt priority and trap control block
package ipt_pkg;

  // ****************************************
  // register map, word addresses on the plain register port
  // ****************************************
  localparam logic [7:0] ADDR_CTRL_ONE   = 8'h00;  // interrupt_control_one
  localparam logic [7:0] ADDR_CTRL_TWO   = 8'h01;  // interrupt_control_two
  localparam logic [7:0] ADDR_STATUS     = 8'h02;  // cpu_status_word
  localparam logic [7:0] ADDR_CORE       = 8'h03;  // core_control_word
  localparam logic [7:0] ADDR_PENDING    = 8'h04;  // pending_vector_reg
  localparam logic [7:0] ADDR_FLAG       = 8'h08;  // request_flag_reg
  localparam logic [7:0] ADDR_ENABLE     = 8'h0C;  // request_enable_reg
  localparam logic [7:0] ADDR_PRIO_BASE  = 8'h10;  // source_priority_reg 0..3

  // ****************************************
  // field positions
  // ****************************************
  localparam int NESTING_DISABLE_BIT = 15;
  localparam int ACC_A_OVF_BIT       = 14;
  localparam int ACC_B_OVF_BIT       = 13;
  localparam int ACC_A_CAT_BIT       = 12;
  localparam int ACC_B_CAT_BIT       = 11;
  localparam int ACC_A_TE_BIT        = 10;
  localparam int ACC_B_TE_BIT        = 9;
  localparam int CAT_TE_BIT          = 8;
  localparam int BAD_SHIFT_BIT       = 7;
  localparam int DIV_ZERO_BIT        = 6;
  localparam int DMA_FAULT_BIT       = 5;
  localparam int MATH_FAULT_BIT      = 4;
  localparam int ADDR_FAULT_BIT      = 3;
  localparam int STACK_FAULT_BIT     = 2;
  localparam int OSC_FAULT_BIT       = 1;
  localparam int ALT_TABLE_BIT       = 15;
  localparam int IPL_LSB             = 5;   // cpu_priority_level in status word 7:5
  localparam int LEVEL_MSB_BIT       = 3;   // priority_level_msb in core control word
  localparam int PRIO_FIELD_STRIDE   = 4;   // priority field k at bits 4k+2:4k
  localparam int PRIO_PER_REG        = 4;
  localparam int NEW_LEVEL_LSB       = 8;   // new_cpu_level at 11:8 of pending word

  // ****************************************
  // values
  // ****************************************
  localparam logic [15:0] RESET_WORD     = 16'h0000;
  localparam logic [2:0]  IPL_MAX        = 3'h7;  // user requests masked here
  localparam logic [6:0]  USER_VEC_BASE  = 7'h08; // first user source vector number
  localparam logic [15:0] CTRL_ONE_MASK  = 16'hFFFE; // bit 0 unimplemented
  localparam logic [2:0]  MASKED_LEVEL   = 3'h7;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ipt_bus_req_s;

  typedef struct packed {
    logic acc_a_ovf;    // accumulator A overflow
    logic acc_b_ovf;
    logic acc_a_cat;    // accumulator A catastrophic overflow
    logic acc_b_cat;
    logic bad_shift;
    logic div_zero;
    logic dma_fault;
    logic addr_fault;
    logic stack_fault;
    logic osc_fault;
  } ipt_trap_evt_s;

  typedef struct packed {
    logic       valid;
    logic [6:0] vector;
    logic [3:0] level;
  } ipt_pending_s;

endpackage : ipt_pkg

// ---- rtl/ipt_ctrl.sv ----
// module: interrupt priority selection, cpu level, nesting and trap status control
`timescale 1ns/100ps

// Function
// - sources set flags, software write clears them
// - one independent enable bit per source
// - per-source priority field, eight levels
// - latch pending vector and its priority level
// - bits allotted to sources in vector order
// - cpu level low bits at status 7:5
// - level msb at core bit 3, never software-set
// - effective level is msb over three bits
// - user requests masked at level 7 or msb
// - nesting disable makes level bits read-only
// - control one bit 15 is nesting disable
// - bits 14,13 flag accumulator overflow traps
// - bits 12,11 flag catastrophic overflow traps
// - bits 10,9,8 enable the overflow traps
// - bit 7 flags invalid shift math trap
// - bit 6 flags divide by zero trap
// - bit 5 flags dma controller error trap
// - bit 4 flags any math error trap
// - control two steers external inputs, table select
// - table select one picks alternate vector table
// - per-pin polarity, one falling, zero rising
// - bits 3,2,1 address, stack, oscillator traps
module ipt_ctrl #(
  parameter int NUM_SRC = 16,
  parameter int NUM_EXT = 5
) (
  input  wire logic                  clk_in,
  input  wire logic                  resetn_in,
  input  wire ipt_pkg::ipt_bus_req_s bus_in,
  output logic [15:0]                rdata_out,
  input  wire logic [NUM_SRC-1:0]    src_event_in,
  input  wire logic [NUM_EXT-1:0]    ext_pin_in,
  input  wire ipt_pkg::ipt_trap_evt_s trap_evt_in,
  input  wire logic                  core_ack_in,
  input  wire logic                  core_level_wr_in,
  input  wire logic [3:0]            core_level_in,
  output ipt_pkg::ipt_pending_s      pending_out,
  output logic [3:0]                 cpu_level_out,
  output logic                       alt_table_out,
  output logic                       math_trap_out
);

  // ****************************************
  // state
  // ****************************************
  logic [NUM_SRC-1:0]   flag_reg;
  logic [NUM_SRC-1:0]   enable_reg;
  logic [2:0]           prio_reg [NUM_SRC];
  logic [2:0]           ipl_reg;
  logic                 level_msb_reg;
  logic [15:0]          ctrl_one_reg;
  logic                 alt_table_reg;
  logic [NUM_EXT-1:0]   polarity_reg;
  logic [NUM_EXT-1:0]   ext_prev_reg;
  ipt_pkg::ipt_pending_s pend_reg;
  logic                 math_trap_reg;
  logic [15:0]          rdata_reg;

  logic [NUM_SRC-1:0]   src_set;
  logic [NUM_EXT-1:0]   ext_edge;
  logic [3:0]           cpl;
  logic                 any_cand;
  logic [6:0]           best_vec;
  logic [2:0]           best_prio;
  logic                 wr_ctrl_one;
  logic                 wr_status;
  logic                 wr_core;
  logic                 math_evt;

  assign wr_ctrl_one = bus_in.wr && (bus_in.addr == ipt_pkg::ADDR_CTRL_ONE);
  assign wr_status   = bus_in.wr && (bus_in.addr == ipt_pkg::ADDR_STATUS);
  assign wr_core     = bus_in.wr && (bus_in.addr == ipt_pkg::ADDR_CORE);

  // effective level: msb stacked above the three status bits
  assign cpl = {level_msb_reg, ipl_reg};

  // ****************************************
  // external pin edge detection
  // ****************************************
  // pins are sampled as synchronous; previous sample gives the edge
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_prev_reg <= '0;
    end else begin
      ext_prev_reg <= ext_pin_in;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      if (g < NUM_EXT) begin : g_ext
        // polarity one catches a falling edge, zero a rising edge
        assign ext_edge[g] = polarity_reg[g] ? (ext_prev_reg[g] && !ext_pin_in[g])
                                             : (!ext_prev_reg[g] && ext_pin_in[g]);
        assign src_set[g]  = src_event_in[g] || ext_edge[g];
      end else begin : g_int
        assign src_set[g]  = src_event_in[g];
      end
    end
  endgenerate

  // ****************************************
  // request flags and enables
  // ****************************************
  // a hardware set in the same cycle as a software clear wins
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flag_reg <= '0;
    end else if (bus_in.wr && bus_in.addr == ipt_pkg::ADDR_FLAG) begin
      flag_reg <= bus_in.wdata[NUM_SRC-1:0] | src_set;
    end else begin
      flag_reg <= flag_reg | src_set;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      enable_reg <= '0;
    end else if (bus_in.wr && bus_in.addr == ipt_pkg::ADDR_ENABLE) begin
      enable_reg <= bus_in.wdata[NUM_SRC-1:0];
    end
  end

  // priority fields, four per word, first source in bits 2:0
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        prio_reg[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (bus_in.wr && bus_in.addr == ipt_pkg::ADDR_PRIO_BASE + 8'(i / ipt_pkg::PRIO_PER_REG)) begin
          prio_reg[i] <= bus_in.wdata[(i % ipt_pkg::PRIO_PER_REG) * ipt_pkg::PRIO_FIELD_STRIDE +: 3];
        end
      end
    end
  end

  // ****************************************
  // priority selection
  // ****************************************
  // highest priority wins; on a tie the lower vector wins (natural order)
  always_comb begin
    any_cand  = 1'b0;
    best_vec  = 7'h00;
    best_prio = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      // level 7 or a set msb leaves no user priority above the level
      if (flag_reg[i] && enable_reg[i] && ({1'b0, prio_reg[i]} > cpl) && (prio_reg[i] >= best_prio)) begin
        any_cand  = 1'b1;
        best_vec  = ipt_pkg::USER_VEC_BASE + 7'(i);
        best_prio = prio_reg[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pend_reg <= '0;
    end else begin
      pend_reg.valid <= any_cand;
      if (any_cand) begin
        pend_reg.vector <= best_vec;
        pend_reg.level  <= {1'b0, best_prio};
      end
    end
  end

  // ****************************************
  // cpu priority level
  // ****************************************
  // core restore beats acknowledge, which beats a software write
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ipl_reg <= 3'h0;
    end else if (core_level_wr_in) begin
      ipl_reg <= core_level_in[2:0];
    end else if (core_ack_in && pend_reg.valid) begin
      // with nesting off, entry raises the level to mask every user source
      ipl_reg <= ctrl_one_reg[ipt_pkg::NESTING_DISABLE_BIT] ? ipt_pkg::MASKED_LEVEL : pend_reg.level[2:0];
    end else if (wr_status && !ctrl_one_reg[ipt_pkg::NESTING_DISABLE_BIT]) begin
      ipl_reg <= bus_in.wdata[ipt_pkg::IPL_LSB +: 3];
    end
  end

  // msb: only the core sets it (trap entry), software may only clear it
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      level_msb_reg <= 1'b0;
    end else if (core_level_wr_in) begin
      level_msb_reg <= core_level_in[3];
    end else if (wr_core && !bus_in.wdata[ipt_pkg::LEVEL_MSB_BIT]) begin
      level_msb_reg <= 1'b0;
    end
  end

  // ****************************************
  // control one: nesting, trap enables and trap status
  // ****************************************
  assign math_evt = (trap_evt_in.acc_a_ovf && ctrl_one_reg[ipt_pkg::ACC_A_TE_BIT])
                 || (trap_evt_in.acc_b_ovf && ctrl_one_reg[ipt_pkg::ACC_B_TE_BIT])
                 || ((trap_evt_in.acc_a_cat || trap_evt_in.acc_b_cat) && ctrl_one_reg[ipt_pkg::CAT_TE_BIT])
                 || trap_evt_in.bad_shift || trap_evt_in.div_zero;

  // status bits set by trap events win over a software write
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_one_reg <= ipt_pkg::RESET_WORD;
    end else begin
      ctrl_one_reg <= (wr_ctrl_one ? (bus_in.wdata & ipt_pkg::CTRL_ONE_MASK) : ctrl_one_reg) | (16'(
          ((trap_evt_in.acc_a_ovf && ctrl_one_reg[ipt_pkg::ACC_A_TE_BIT]) << ipt_pkg::ACC_A_OVF_BIT)
        | ((trap_evt_in.acc_b_ovf && ctrl_one_reg[ipt_pkg::ACC_B_TE_BIT]) << ipt_pkg::ACC_B_OVF_BIT)
        | ((trap_evt_in.acc_a_cat && ctrl_one_reg[ipt_pkg::CAT_TE_BIT]) << ipt_pkg::ACC_A_CAT_BIT)
        | ((trap_evt_in.acc_b_cat && ctrl_one_reg[ipt_pkg::CAT_TE_BIT]) << ipt_pkg::ACC_B_CAT_BIT)
        | (trap_evt_in.bad_shift << ipt_pkg::BAD_SHIFT_BIT)
        | (trap_evt_in.div_zero << ipt_pkg::DIV_ZERO_BIT)
        | (trap_evt_in.dma_fault << ipt_pkg::DMA_FAULT_BIT)
        | (math_evt << ipt_pkg::MATH_FAULT_BIT)
        | (trap_evt_in.addr_fault << ipt_pkg::ADDR_FAULT_BIT)
        | (trap_evt_in.stack_fault << ipt_pkg::STACK_FAULT_BIT)
        | (trap_evt_in.osc_fault << ipt_pkg::OSC_FAULT_BIT)));
    end
  end

  // one-cycle pulse to the core for every math trap cause
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      math_trap_reg <= 1'b0;
    end else begin
      math_trap_reg <= math_evt;
    end
  end

  // ****************************************
  // control two: table select and pin polarity
  // ****************************************
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      alt_table_reg <= 1'b0;
      polarity_reg  <= '0;
    end else if (bus_in.wr && bus_in.addr == ipt_pkg::ADDR_CTRL_TWO) begin
      alt_table_reg <= bus_in.wdata[ipt_pkg::ALT_TABLE_BIT];
      polarity_reg  <= bus_in.wdata[NUM_EXT-1:0];
    end
  end

  // ****************************************
  // read port, data in the cycle after the strobe
  // ****************************************
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_reg <= 16'h0000;
    end else if (bus_in.rd) begin
      rdata_reg <= 16'h0000;  // unmapped addresses read zero
      unique case (bus_in.addr)
        ipt_pkg::ADDR_CTRL_ONE: rdata_reg <= ctrl_one_reg;
        ipt_pkg::ADDR_CTRL_TWO: rdata_reg <= 16'({alt_table_reg, 15'(polarity_reg)});
        ipt_pkg::ADDR_STATUS:   rdata_reg <= 16'({ipl_reg, 5'h00});
        ipt_pkg::ADDR_CORE:     rdata_reg <= 16'({level_msb_reg, 3'h0});
        ipt_pkg::ADDR_PENDING:  rdata_reg <= 16'({pend_reg.level, 1'b0, pend_reg.vector});
        ipt_pkg::ADDR_FLAG:     rdata_reg <= 16'(flag_reg);
        ipt_pkg::ADDR_ENABLE:   rdata_reg <= 16'(enable_reg);
        default: begin
          for (int r = 0; r < NUM_SRC / ipt_pkg::PRIO_PER_REG; r++) begin
            if (bus_in.addr == ipt_pkg::ADDR_PRIO_BASE + 8'(r)) begin
              rdata_reg <= {1'b0, prio_reg[4*r+3], 1'b0, prio_reg[4*r+2],
                            1'b0, prio_reg[4*r+1], 1'b0, prio_reg[4*r]};
            end
          end
        end
      endcase
    end
  end

  assign rdata_out     = rdata_reg;
  assign pending_out   = pend_reg;
  assign cpu_level_out = cpl;
  assign alt_table_out = alt_table_reg;
  assign math_trap_out = math_trap_reg;

  // ****************************************
  // assertions
  // ****************************************
  AST_FLAG_SET: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (src_set != '0) |=> ((flag_reg & $past(src_set)) == $past(src_set)))
    else $error("source event did not set its flag");

  AST_MASKED: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (level_msb_reg || ipl_reg == ipt_pkg::IPL_MAX) |=> !pend_reg.valid)
    else $error("user request presented while masked");

  AST_ABOVE_LEVEL: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(pend_reg.valid) |-> (pend_reg.level > $past(cpl)))
    else $error("pending level not above cpu level");

  AST_VEC_RANGE: assert property (@(posedge clk_in) disable iff (!resetn_in)
    pend_reg.valid |-> (pend_reg.vector >= ipt_pkg::USER_VEC_BASE && pend_reg.vector < ipt_pkg::USER_VEC_BASE + 7'(NUM_SRC)))
    else $error("pending vector outside user range");

  AST_IPL_LOCK: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_status && ctrl_one_reg[ipt_pkg::NESTING_DISABLE_BIT] && !core_level_wr_in && !core_ack_in) |=> $stable(ipl_reg))
    else $error("level bits changed by software while nesting disabled");

  AST_MSB_NO_SET: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!level_msb_reg && !core_level_wr_in) |=> !level_msb_reg)
    else $error("level msb set without the core");

  AST_READ_IPL: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (bus_in.rd && bus_in.addr == ipt_pkg::ADDR_STATUS) |=> (rdata_out[7:5] == $past(ipl_reg) && rdata_out[4:0] == 5'h00))
    else $error("status read did not return the level");

  AST_RISE_EDGE: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!polarity_reg[0] && !ext_prev_reg[0] && ext_pin_in[0]) |=> flag_reg[0] ##1 flag_reg[0] || $past(bus_in.wr))
    else $error("rising edge did not raise external request");

  AST_DIV_MATH: assert property (@(posedge clk_in) disable iff (!resetn_in)
    trap_evt_in.div_zero |=> (ctrl_one_reg[ipt_pkg::DIV_ZERO_BIT] && ctrl_one_reg[ipt_pkg::MATH_FAULT_BIT] && math_trap_out))
    else $error("divide trap status not raised");

  AST_ACK_LEVEL: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (core_ack_in && pend_reg.valid && !core_level_wr_in && ctrl_one_reg[ipt_pkg::NESTING_DISABLE_BIT])
      |=> (ipl_reg == ipt_pkg::MASKED_LEVEL) ##1 !pend_reg.valid)
    else $error("nesting disable did not mask further requests");

  AST_FLAG_CLEAR: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (bus_in.wr && bus_in.addr == ipt_pkg::ADDR_FLAG && src_set == '0)
      |=> (flag_reg == $past(bus_in.wdata[NUM_SRC-1:0])))
    else $error("software write did not clear flags");

  AST_ENABLED: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(pend_reg.valid) |-> ($past(flag_reg & enable_reg) != '0))
    else $error("request presented without flag and enable");

  AST_ACK_LOAD: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (core_ack_in && pend_reg.valid && !core_level_wr_in && !ctrl_one_reg[ipt_pkg::NESTING_DISABLE_BIT])
      |=> (ipl_reg == $past(pend_reg.level[2:0])))
    else $error("acknowledge did not load the pending level");

  AST_MSB_CLEAR: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_core && !bus_in.wdata[ipt_pkg::LEVEL_MSB_BIT] && !core_level_wr_in) |=> !level_msb_reg)
    else $error("software clear of level msb lost");

  AST_NEST_WRITE: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_ctrl_one |=> (ctrl_one_reg[ipt_pkg::NESTING_DISABLE_BIT] == $past(bus_in.wdata[ipt_pkg::NESTING_DISABLE_BIT])))
    else $error("nesting disable bit not written");

  AST_TRAP_GATE: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (trap_evt_in.acc_a_ovf && !ctrl_one_reg[ipt_pkg::ACC_A_TE_BIT] && !wr_ctrl_one && !ctrl_one_reg[ipt_pkg::ACC_A_OVF_BIT])
      |=> !ctrl_one_reg[ipt_pkg::ACC_A_OVF_BIT])
    else $error("disabled overflow trap raised its flag");

  AST_ALT_TABLE: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (bus_in.wr && bus_in.addr == ipt_pkg::ADDR_CTRL_TWO)
      |=> (alt_table_out == $past(bus_in.wdata[ipt_pkg::ALT_TABLE_BIT])))
    else $error("table select not written");

  AST_DMA_FLAG: assert property (@(posedge clk_in) disable iff (!resetn_in)
    trap_evt_in.dma_fault |=> ctrl_one_reg[ipt_pkg::DMA_FAULT_BIT])
    else $error("dma fault status not raised");

  AST_SHIFT_FLAG: assert property (@(posedge clk_in) disable iff (!resetn_in)
    trap_evt_in.bad_shift |=> (ctrl_one_reg[ipt_pkg::BAD_SHIFT_BIT] && math_trap_out))
    else $error("bad shift status not raised");

  AST_FALL_EDGE: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (polarity_reg[1] && ext_prev_reg[1] && !ext_pin_in[1]) |=> flag_reg[1])
    else $error("falling edge did not raise external request");

endmodule : ipt_ctrl

// ---- tb/ipt_core_model.sv ----
// core-side model: takes pending interrupts and loads trap entry levels
`timescale 1ns/100ps
module ipt_core_model (
  input  wire logic                  clk_in,
  input  wire logic                  resetn_in,
  input  wire ipt_pkg::ipt_pending_s pending_in,
  input  wire logic                  ack_en_in,
  input  wire logic [3:0]            ack_delay_in,
  input  wire logic                  trap_go_in,
  output logic                       ack_out,
  output logic                       level_wr_out,
  output logic [3:0]                 level_out
);
  logic [3:0] wait_reg;
  logic       busy_reg;
  // ack after a programmable stall; one ack per request, so wait for the drop
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_reg <= 4'h0;
      busy_reg <= 1'b0;
      ack_out  <= 1'b0;
    end else begin
      ack_out <= 1'b0;
      if (!pending_in.valid) begin
        busy_reg <= 1'b0;
      end
      if (!ack_en_in || !pending_in.valid || busy_reg) begin
        wait_reg <= 4'h0;
      end else if (wait_reg >= ack_delay_in) begin
        ack_out  <= 1'b1;
        busy_reg <= 1'b1;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
  // trap entry loads level 8; the level bus wanders while not strobed
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      level_wr_out <= 1'b0;
      level_out    <= 4'h5;
    end else begin
      level_wr_out <= trap_go_in;
      level_out    <= trap_go_in ? 4'h8 : level_out + 4'h3;
    end
  end
endmodule : ipt_core_model

// ---- tb/testbench.sv ----
// self-checking bench of the interrupt priority and trap control block
`timescale 1ns/100ps
module testbench;
  logic                   clk_in;
  logic                   resetn_in;
  ipt_pkg::ipt_bus_req_s  bus_in;
  logic [15:0]            rdata_out;
  logic [15:0]            src_event_in;
  logic [4:0]             ext_pin_in;
  ipt_pkg::ipt_trap_evt_s trap_evt_in;
  ipt_pkg::ipt_pending_s  pending_out;
  logic [3:0]             cpu_level_out;
  logic                   alt_table_out;
  logic                   math_trap_out;
  logic                   core_ack, core_wr, ack_en, trap_go, en, exp_v;
  logic [3:0]             core_lvl, ack_delay;
  logic [31:0]            rng;
  logic [15:0]            rd_val;
  int                     fail_count, cmp_count, idx, prio, lvl;
  localparam int TBIT[10] = '{14, 13, 12, 11, 7, 6, 5, 3, 2, 1};
  ipt_ctrl ipt_ctrl_inst (.clk_in(clk_in), .resetn_in(resetn_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .src_event_in(src_event_in), .ext_pin_in(ext_pin_in), .trap_evt_in(trap_evt_in), .core_ack_in(core_ack),
    .core_level_wr_in(core_wr), .core_level_in(core_lvl), .pending_out(pending_out),
    .cpu_level_out(cpu_level_out), .alt_table_out(alt_table_out), .math_trap_out(math_trap_out));
  ipt_core_model ipt_core_model_inst (.clk_in(clk_in), .resetn_in(resetn_in), .pending_in(pending_out),
    .ack_en_in(ack_en), .ack_delay_in(ack_delay), .trap_go_in(trap_go), .ack_out(core_ack),
    .level_wr_out(core_wr), .level_out(core_lvl));
  always #5 clk_in = ~clk_in;
  function automatic int next_rand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return int'(rng & 32'h7FFF_FFFF);
  endfunction : next_rand
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one-cycle strobes with an idle cycle after, so no signal is driven twice per step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_in <= '0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_in <= '0;
    @(posedge clk_in);
    rd_val = rdata_out;
  endtask : rd
  task automatic fire(input int k);
    src_event_in <= 16'h0001 << k;
    @(posedge clk_in);
    src_event_in <= 16'h0000;
    repeat (2) @(posedge clk_in);
  endtask : fire
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    clk_in = 1'b0;
    resetn_in = 1'b0;
    bus_in = '0;
    src_event_in = 16'h0000;
    ext_pin_in = 5'h00;
    trap_evt_in = '0;
    {ack_en, trap_go, ack_delay} = 6'h00;
    rng = 32'd61;
    fail_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    // reset values, unmapped address last
    foreach (TBIT[i]) begin
      rd(8'(i < 7 ? i : 63));
      chk("reset word", rd_val, 16'h0000);
    end
    wr(8'h00, 16'hFFFF);
    rd(8'h00);
    chk("control one", rd_val, 16'hFFFE);
    wr(8'h02, 16'h00E0);
    chk("locked level", cpu_level_out, 16'h0000);
    wr(8'h00, 16'h0000);
    wr(8'h02, 16'h0060);
    rd(8'h02);
    chk("status level", rd_val[7:5], 16'h0003);
    wr(8'h03, 16'h0008);
    chk("cpu level", cpu_level_out, 16'h0003);
    // random sources with boundary cases first
    for (int i = 0; i < 14; i++) begin
      idx = next_rand() % 16;
      prio = 1 + next_rand() % 7;
      lvl = next_rand() % 7;
      en = (i % 4 != 3);
      if (i == 0) begin
        {idx, prio, lvl} = {32'd15, 32'd7, 32'd7};
      end
      if (i == 1) begin
        {idx, prio, lvl} = {32'd0, 32'd4, 32'd4};
      end
      wr(8'h02, 16'(lvl << 5));
      wr(8'(8'h10 + idx / 4), 16'(prio << (4 * (idx % 4))));
      wr(8'h0C, 16'(en) << idx);
      rd(8'(8'h10 + idx / 4));
      chk("priority field", rd_val, 16'(prio << (4 * (idx % 4))));
      fire(idx);
      exp_v = en && (prio > lvl);
      chk("pending valid", pending_out.valid, exp_v);
      if (exp_v) begin
        chk("vector level", {pending_out.vector, pending_out.level}, 16'((8 + idx) * 16 + prio));
        rd(8'h04);
        chk("pending word", rd_val, 16'(prio * 256 + 8 + idx));
      end
      rd(8'h08);
      chk("flag set", rd_val, 16'h0001 << idx);
      wr(8'h08, 16'h0000);
      rd(8'h08);
      chk("flag clear", rd_val, 16'h0000);
    end
    // equal priorities: the lower source number wins
    wr(8'h02, 16'h0000);
    wr(8'h10, 16'h3300);
    wr(8'h0C, 16'h000C);
    fire(3);
    fire(2);
    chk("tie vector", pending_out.vector, 16'h000A);
    wr(8'h08, 16'h0000);
    // core takes a request after a slow stall, then a trap entry masks users
    wr(8'h02, 16'h0000);
    wr(8'h10, 16'h0500);
    wr(8'h0C, 16'h0004);
    ack_delay <= 4'h3;
    ack_en <= 1'b1;
    fire(2);
    repeat (8) @(posedge clk_in);
    chk("acked level", cpu_level_out, 16'h0005);
    chk("pending after ack", pending_out.valid, 16'h0000);
    ack_en <= 1'b0;
    wr(8'h08, 16'h0000);
    trap_go <= 1'b1;
    @(posedge clk_in);
    trap_go <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk("trap level", cpu_level_out, 16'h0008);
    rd(8'h03);
    chk("level msb", rd_val[3], 16'h0001);
    wr(8'h10, 16'h0700);
    fire(2);
    chk("msb masks", pending_out.valid, 16'h0000);
    wr(8'h03, 16'h0000);
    @(posedge clk_in);
    chk("unmasked", pending_out.valid, 16'h0001);
    wr(8'h00, 16'h8000);
    ack_delay <= 4'h0;
    ack_en <= 1'b1;
    repeat (4) @(posedge clk_in);
    ack_en <= 1'b0;
    chk("nested off level", cpu_level_out, 16'h0007);
    wr(8'h02, 16'h0000);
    rd(8'h02);
    chk("status locked", rd_val[7:5], 16'h0007);
    // every trap cause with its enables set, then one with enables clear
    foreach (TBIT[i]) begin
      wr(8'h00, 16'h0700);
      trap_evt_in <= 10'h200 >> i;
      @(posedge clk_in);
      trap_evt_in <= '0;
      @(posedge clk_in);
      chk("math pulse", math_trap_out, 16'(i < 6));
      rd(8'h00);
      chk("trap flags", rd_val, 16'h0700 | (16'h0001 << TBIT[i]) | 16'((i < 6) << 4));
    end
    wr(8'h00, 16'h0000);
    trap_evt_in <= 10'h200;
    @(posedge clk_in);
    trap_evt_in <= '0;
    rd(8'h00);
    chk("disabled trap", rd_val, 16'h0000);
    // control two: alternate table and pin polarity, pin 1 on falling edges
    wr(8'h01, 16'h8002);
    chk("alt table", alt_table_out, 16'h0001);
    rd(8'h01);
    chk("control two", rd_val, 16'h8002);
    wr(8'h08, 16'h0000);
    ext_pin_in <= 5'h03;
    repeat (4) @(posedge clk_in);
    rd(8'h08);
    chk("rising pins", rd_val, 16'h0001);
    ext_pin_in <= 5'h00;
    repeat (4) @(posedge clk_in);
    rd(8'h08);
    chk("falling pins", rd_val, 16'h0003);
    report_and_stop();
  end
  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end
endmodule : testbench
